// ===== rtl/cps_pkg.sv
// package of register map, primitive codes and carriers for the coprocessor sequencer
package cps_pkg;
   // ----------------------------------------
   // register byte offsets
   // ----------------------------------------
   localparam logic [7:0] CPS_OFS_RESPONSE = 8'h00; // response word, read
   localparam logic [7:0] CPS_OFS_CONTROL = 8'h04; // control strobes, write
   localparam logic [7:0] CPS_OFS_COMMAND = 8'h08; // general command, write
   localparam logic [7:0] CPS_OFS_CONDITION = 8'h0C; // branch/conditional command, write
   localparam logic [7:0] CPS_OFS_OPERAND = 8'h10; // operand register, read/write
   localparam logic [7:0] CPS_OFS_STATUS = 8'h14; // sequencer status, read
   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int CPS_CTL_EXC_ACK = 0; // control: acknowledge exception
   localparam int CPS_CTL_RESUME = 1; // control: resume suspended instruction
   localparam int CPS_CTL_CLR_ERR = 2; // control: clear bus error flag
   localparam int CPS_RSP_CA = 15; // response: come-again flag
   localparam int CPS_RSP_PF = 8; // response: processing-finished flag (null)
   localparam int CPS_FN_HI = 13; // response: primitive function field top
   localparam int CPS_FN_LO = 9; // response: primitive function field bottom
   // ----------------------------------------
   // primitive function codes and words
   // ----------------------------------------
   localparam logic [4:0] CPS_FN_NULL = 5'h00; // null primitive
   localparam logic [4:0] CPS_FN_EXC = 5'h1C; // exception primitive
   localparam logic [4:0] CPS_FN_EA_EVAL = 5'h14; // evaluate effective address
   localparam logic [4:0] CPS_FN_PREV_EA = 5'h15; // reuse previous effective address
   localparam logic [4:0] CPS_FN_ADDR_XFER = 5'h16; // address from coprocessor with data
   localparam logic [4:0] CPS_FN_SR_SCAN = 5'h01; // status register / scan program counter
   localparam logic [7:0] CPS_VEC_PROTOCOL = 8'h0D; // protocol violation vector
   localparam logic [15:0] CPS_RSP_BUSY = 16'h8000; // null with come-again, poll again
   localparam logic [15:0] CPS_RSP_RESET = 16'h0100; // null done, processing finished
   // ----------------------------------------
   // types
   // ----------------------------------------
   typedef enum logic [1:0] {
      CPS_IDLE = 2'b00, // no instruction in progress
      CPS_BUSY = 2'b01, // waiting for the engine's next primitive
      CPS_POSTED = 2'b11, // primitive waiting for main processor read
      CPS_EXC = 2'b10 // exception requested, dialogue frozen
   } cps_state_e;
   typedef struct packed {
      logic cyc; // bus cycle
      logic stb; // strobe
      logic we; // write
      logic [31:0] adr; // full byte address
      logic [3:0] sel; // byte selects
      logic [31:0] dat; // write data
   } cps_wbm_s;
endpackage : cps_pkg

// ===== rtl/cps_sequencer.sv
// coprocessor side of the interprocessor protocol with wishbone slave and optional bus master
`timescale 1ns/100ps
module cps_sequencer import cps_pkg::*; #(
   parameter bit DMA_CAPABLE = 1'b1 // coprocessor may master the bus
) (
   input wire logic mclk, // clock, 25 MHz
   input wire logic rst, // synchronous reset, active high
   input wire logic wb_cyc, // slave cycle
   input wire logic wb_stb, // slave strobe
   input wire logic wb_we, // slave write
   input wire logic [7:0] wb_adr, // slave byte address
   input wire logic [3:0] wb_sel, // slave byte selects
   input wire logic [31:0] wb_dat_i, // slave write data
   output logic [31:0] wb_dat_o, // slave read data
   output logic wb_ack, // slave acknowledge
   output logic cmd_start, // pulse: new command taken
   output logic cmd_branch, // command is branch/conditional type
   output logic [15:0] cmd_word, // command word
   input wire logic rsp_valid, // engine offers a primitive
   input wire logic [15:0] rsp_word, // engine primitive word
   output logic rsp_ready, // primitive accepted this cycle
   input wire logic opnd_load, // engine loads operand register
   input wire logic [31:0] opnd_in, // engine operand value
   output logic [31:0] opnd_out, // operand register contents
   output logic opnd_wr, // pulse: processor wrote operand
   output logic exc_ack, // pulse: exception acknowledged
   output logic resume, // pulse: suspended instruction resumed
   input wire logic dma_req, // engine asks for a bus cycle
   input wire logic dma_we, // engine cycle is a write
   input wire logic [31:0] dma_addr, // engine cycle address
   input wire logic [31:0] dma_wdata, // engine write data
   output logic dma_done, // pulse: cycle ended with ack
   output logic dma_fail, // pulse: cycle ended with error
   output logic [31:0] dma_rdata, // data read by the cycle
   output cps_wbm_s m_req, // master request
   input wire logic [31:0] m_dat_i, // master read data
   input wire logic m_ack, // master normal termination
   input wire logic m_err, // master error termination
   input wire logic m_rty // master retry termination
);
   // ----------------------------------------
   // slave decode
   // ----------------------------------------
   logic acc; // request not yet answered
   logic wr; // write taken this cycle
   logic rd; // read taken this cycle
   assign acc = wb_cyc && wb_stb && !wb_ack;
   assign wr = acc && wb_we;
   assign rd = acc && !wb_we;
   cps_state_e state, next_state; // dialogue state
   logic [15:0] resp, next_resp; // response register
   logic [31:0] opnd, next_opnd; // operand register
   logic branch, next_branch; // current instruction is branch type
   logic bus_err, next_bus_err; // sticky master error
   logic ack_q, next_ack_q; // slave acknowledge
   logic [31:0] rdat, next_rdat; // registered read data
   logic [15:0] cmd_q, next_cmd_q; // command word
   logic start_q, next_start_q; // command pulse
   logic opw_q, next_opw_q; // operand write pulse
   logic exa_q, next_exa_q; // exception ack pulse
   logic res_q, next_res_q; // resume pulse
   logic [15:0] legal; // engine word after branch filter
   logic [4:0] fn; // engine function field
   logic bad_fn; // function barred in branch instructions
   logic ends; // read primitive ends the dialogue
   // ----------------------------------------
   // primitive filter
   // ----------------------------------------
   // barred primitives in branch mode become a protocol violation exception
   always_comb begin
      fn = rsp_word[CPS_FN_HI:CPS_FN_LO];
      bad_fn = (fn == CPS_FN_EA_EVAL) || (fn == CPS_FN_PREV_EA) ||
               (fn == CPS_FN_ADDR_XFER) || (fn == CPS_FN_SR_SCAN);
      if (branch && bad_fn) begin
         legal = {2'b00, CPS_FN_EXC, 1'b0, CPS_VEC_PROTOCOL};
      end else begin
         legal = rsp_word;
      end
   end
   assign rsp_ready = (state == CPS_BUSY);
   // the dialogue ends on a read primitive when
   // branch: only null-done or exception; general: any without come-again
   always_comb begin
      if (branch) begin
         ends = !resp[CPS_RSP_CA] && (resp[CPS_FN_HI:CPS_FN_LO] == CPS_FN_NULL);
      end else begin
         ends = !resp[CPS_RSP_CA];
      end
   end
   // ----------------------------------------
   // dialogue and register file, next values
   // ----------------------------------------
   always_comb begin
      next_state = state;
      next_resp = resp;
      next_opnd = opnd;
      next_branch = branch;
      next_bus_err = bus_err;
      next_ack_q = acc;
      next_rdat = 32'h00000000;
      next_cmd_q = cmd_q;
      next_start_q = 1'b0;
      next_opw_q = 1'b0;
      next_exa_q = 1'b0;
      next_res_q = 1'b0;
      // register reads, unmapped reads answer zero
      if (rd) begin
         unique case (wb_adr)
            CPS_OFS_RESPONSE: next_rdat = {16'h0000, resp};
            CPS_OFS_OPERAND: next_rdat = opnd;
            CPS_OFS_STATUS: next_rdat = {28'h0000000, bus_err, branch, state};
            default: next_rdat = 32'h00000000;
         endcase
      end
      // operand path: processor mediated transfers
      if (wr && wb_adr == CPS_OFS_OPERAND) begin
         for (int b = 0; b < 4; b++) begin
            if (wb_sel[b]) begin
               next_opnd[8*b +: 8] = wb_dat_i[8*b +: 8];
            end
         end
         next_opw_q = 1'b1;
      end else if (opnd_load) begin
         next_opnd = opnd_in;
      end
      // state sequencing
      unique case (state)
         CPS_IDLE: begin
            next_resp = CPS_RSP_RESET;
         end
         CPS_BUSY: begin
            if (rsp_valid) begin
               next_resp = legal;
               next_state = CPS_POSTED;
            end
         end
         CPS_POSTED: begin
            // held until read, so rereads match
            if (rd && wb_adr == CPS_OFS_RESPONSE) begin
               if (resp[CPS_FN_HI:CPS_FN_LO] == CPS_FN_EXC) begin
                  next_state = CPS_EXC;
               end else if (ends) begin
                  next_state = CPS_IDLE;
               end else begin // come-again, or non-null in branch: poll until next primitive
                  next_resp = CPS_RSP_BUSY;
                  next_state = CPS_BUSY;
               end
            end
         end
         CPS_EXC: begin
            // frozen until a new command or a resume
            if (wr && wb_adr == CPS_OFS_CONTROL && wb_dat_i[CPS_CTL_RESUME]) begin
               next_resp = CPS_RSP_BUSY;
               next_state = CPS_BUSY;
               next_res_q = 1'b1;
            end
         end
      endcase
      // control strobes
      if (wr && wb_adr == CPS_OFS_CONTROL) begin
         next_exa_q = wb_dat_i[CPS_CTL_EXC_ACK] && (state == CPS_EXC);
         if (wb_dat_i[CPS_CTL_CLR_ERR]) begin
            next_bus_err = 1'b0;
         end
      end
      // a command write always begins a new instruction
      if (wr && (wb_adr == CPS_OFS_COMMAND || wb_adr == CPS_OFS_CONDITION)) begin
         next_cmd_q = wb_dat_i[15:0];
         next_branch = (wb_adr == CPS_OFS_CONDITION);
         next_start_q = 1'b1;
         next_resp = CPS_RSP_BUSY;
         next_state = CPS_BUSY;
      end
      // error set wins over software clear
      if (m_req.cyc && m_err) begin
         next_bus_err = 1'b1;
      end
   end
   always_ff @(posedge mclk) begin
      if (rst) begin
         state <= CPS_IDLE;
         resp <= CPS_RSP_RESET;
         opnd <= 32'h00000000;
         branch <= 1'b0;
         bus_err <= 1'b0;
         ack_q <= 1'b0;
         rdat <= 32'h00000000;
         cmd_q <= 16'h0000;
         start_q <= 1'b0;
         opw_q <= 1'b0;
         exa_q <= 1'b0;
         res_q <= 1'b0;
      end else begin
         state <= next_state;
         resp <= next_resp;
         opnd <= next_opnd;
         branch <= next_branch;
         bus_err <= next_bus_err;
         ack_q <= next_ack_q;
         rdat <= next_rdat;
         cmd_q <= next_cmd_q;
         start_q <= next_start_q;
         opw_q <= next_opw_q;
         exa_q <= next_exa_q;
         res_q <= next_res_q;
      end
   end
   assign wb_ack = ack_q;
   assign wb_dat_o = rdat;
   assign cmd_start = start_q;
   assign cmd_branch = branch;
   assign cmd_word = cmd_q;
   assign opnd_out = opnd;
   assign opnd_wr = opw_q;
   assign exc_ack = exa_q;
   assign resume = res_q;
   // ----------------------------------------
   // bus master
   // ----------------------------------------
   cps_wbm_s mreq, next_mreq; // master request register
   logic [31:0] mrd, next_mrd; // master read data
   logic mdone, next_mdone; // done pulse
   logic mfail, next_mfail; // fail pulse
   // one cycle per request; retry reissues, ack or err ends it
   always_comb begin
      next_mreq = mreq;
      next_mrd = mrd;
      next_mdone = 1'b0;
      next_mfail = 1'b0;
      if (!mreq.cyc) begin
         if (DMA_CAPABLE && dma_req && !mdone && !mfail) begin
            next_mreq.cyc = 1'b1;
            next_mreq.stb = 1'b1;
            next_mreq.we = dma_we;
            next_mreq.adr = dma_addr;
            next_mreq.sel = 4'hF;
            next_mreq.dat = dma_wdata;
         end
      end else if (m_ack || m_err || m_rty) begin
         next_mreq.cyc = 1'b0;
         next_mreq.stb = 1'b0;
         next_mdone = m_ack;
         next_mfail = m_err && !m_ack;
         if (m_ack && !mreq.we) begin
            next_mrd = m_dat_i;
         end
      end
   end
   always_ff @(posedge mclk) begin
      if (rst) begin
         mreq <= '0;
         mrd <= 32'h00000000;
         mdone <= 1'b0;
         mfail <= 1'b0;
      end else begin
         mreq <= next_mreq;
         mrd <= next_mrd;
         mdone <= next_mdone;
         mfail <= next_mfail;
      end
   end
   assign m_req = mreq;
   assign dma_done = mdone;
   assign dma_fail = mfail;
   assign dma_rdata = mrd;
   // ----------------------------------------
   // assertions
   // ----------------------------------------
   property p_ack_one;
      @(posedge mclk) disable iff (rst) (wb_cyc && wb_stb && !wb_ack) |=> wb_ack ##1 !wb_ack;
   endproperty
   a_ack_one: assert property (p_ack_one) else $error("slave ack not one cycle");
   property p_cmd_busy;
      @(posedge mclk) disable iff (rst) cmd_start |-> state == CPS_BUSY && resp == CPS_RSP_BUSY;
   endproperty
   a_cmd_busy: assert property (p_cmd_busy) else $error("command did not start dialogue");
   property p_hold;
      @(posedge mclk) disable iff (rst) (state == CPS_POSTED && !wr && !rd) |=> $stable(resp);
   endproperty
   a_hold: assert property (p_hold) else $error("response changed between reads");
   property p_branch_filter;
      @(posedge mclk) disable iff (rst)
         (state == CPS_BUSY && rsp_valid && branch && bad_fn && !wr) |=> resp[CPS_FN_HI:CPS_FN_LO] == CPS_FN_EXC;
   endproperty
   a_branch_filter: assert property (p_branch_filter) else $error("barred primitive passed");
   property p_branch_end;
      @(posedge mclk) disable iff (rst)
         (branch && state == CPS_POSTED && $past(state) == CPS_POSTED ##1 state == CPS_IDLE)
         |-> $past(resp[CPS_FN_HI:CPS_FN_LO]) == CPS_FN_NULL;
   endproperty
   a_branch_end: assert property (p_branch_end) else $error("branch ended without null-done");
   property p_exc_freeze;
      @(posedge mclk) disable iff (rst) (state == CPS_EXC && !wr) |=> state == CPS_EXC;
   endproperty
   a_exc_freeze: assert property (p_exc_freeze) else $error("dialogue left exception state");
   property p_general_end;
      @(posedge mclk) disable iff (rst)
         (!branch && state == CPS_POSTED && rd && wb_adr == CPS_OFS_RESPONSE && !resp[CPS_RSP_CA]
          && resp[CPS_FN_HI:CPS_FN_LO] != CPS_FN_EXC && !wr) |=> state == CPS_IDLE;
   endproperty
   a_general_end: assert property (p_general_end) else $error("general did not end");
   property p_dma_end;
      @(posedge mclk) disable iff (rst) (m_req.cyc && (m_ack || m_err || m_rty)) |=> !m_req.cyc;
   endproperty
   a_dma_end: assert property (p_dma_end) else $error("termination not honoured");
   property p_dma_addr;
      @(posedge mclk) disable iff (rst) (m_req.cyc && !$past(m_req.cyc)) |-> m_req.adr == $past(dma_addr);
   endproperty
   a_dma_addr: assert property (p_dma_addr) else $error("master address wrong");
   c_general: cover property (@(posedge mclk) disable iff (rst) cmd_start && !branch ##[1:50] state == CPS_IDLE);
   c_exc: cover property (@(posedge mclk) disable iff (rst) state == CPS_EXC ##[1:50] resume);
   c_dma: cover property (@(posedge mclk) disable iff (rst) dma_done);
endmodule : cps_sequencer

// ===== verif/cps_host_model.sv
// main processor model driving the coprocessor register bus
`timescale 1ns/100ps
module cps_host_model import cps_pkg::*; (
   input wire logic mclk, // clock
   output logic wb_cyc, // cycle
   output logic wb_stb, // strobe
   output logic wb_we, // write
   output logic [7:0] wb_adr, // address
   output logic [3:0] wb_sel, // lanes
   output logic [31:0] wb_dat_o, // write data
   input wire logic [31:0] wb_dat_i, // read data
   input wire logic wb_ack, // acknowledge
   output logic bus_timeout // no ack came
);
   logic [31:0] mem [0:3]; // system memory
   logic [31:0] temp; // temporary register
   logic [1:0] last_act; // 0 next, 1 reread, 2 trace, 3 interrupt
   initial begin
      {wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_dat_o, bus_timeout} = '0;
      for (int i = 0; i < 4; i++) begin
         mem[i] = 32'h1111_1111 * (i + 1);
      end
   end
   // one classic cycle, held until ack is sampled
   task automatic xfer(input logic we, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d,
      output logic [31:0] q);
      int n;
      @(posedge mclk);
      {wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_dat_o} <= {2'b11, we, a, s, d};
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (wb_ack !== 1'b1 && n < 40);
      bus_timeout <= (wb_ack !== 1'b1);
      q = wb_dat_i;
      {wb_cyc, wb_stb, wb_we, wb_adr, wb_dat_o} <= {3'b000, ~a, ~d}; // strobes and we drop, released address and data flip
   endtask : xfer
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      xfer(1'b1, a, 4'hF, d, q);
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      xfer(1'b0, a, 4'hF, 32'h0000_0000, q);
   endtask : rd
   // memory operand in: aligned whole words only
   task automatic mem_to_cop(input int i);
      temp = mem[i];
      wr(CPS_OFS_OPERAND, temp);
   endtask : mem_to_cop
   task automatic cop_to_mem(input int i);
      rd(CPS_OFS_OPERAND, temp);
      mem[i] = temp;
   endtask : cop_to_mem
   task automatic command(input logic br, input logic [15:0] w);
      wr(br ? CPS_OFS_CONDITION : CPS_OFS_COMMAND, {16'h0000, w});
   endtask : command
   // termination rows, first match wins
   function automatic logic [1:0] term_action(input logic ca, pf, tp, ia, ip);
      if (!ca && !tp) return 2'd0;
      if (!ca && !pf) return 2'd1;
      if (!ca) return 2'd2;
      if (ia && ip) return 2'd3;
      return 2'd1;
   endfunction : term_action
   // read the response and decide how the instruction ends
   task automatic get_rsp(input logic tp, input logic ia, input logic ip, output logic [15:0] r);
      logic [31:0] q;
      logic pf;
      rd(CPS_OFS_RESPONSE, q);
      r = q[15:0];
      pf = (r[CPS_FN_HI:CPS_FN_LO] == CPS_FN_NULL) ? r[CPS_RSP_PF] : 1'b0;
      last_act = term_action(r[CPS_RSP_CA], pf, tp, ia, ip);
   endtask : get_rsp
endmodule : cps_host_model

// ===== verif/coprocessor_protocol_sequencer_test.sv
// self-checking bench of the coprocessor protocol sequencer
`timescale 1ns/100ps
module coprocessor_protocol_sequencer_test import cps_pkg::*; ();
   logic mclk, rst, wb_cyc, wb_stb, wb_we, wb_ack, cmd_start, cmd_branch, rsp_valid, rsp_ready;
   logic [7:0] wb_adr;
   logic [3:0] wb_sel;
   logic [31:0] wb_dat_i, wb_dat_o, opnd_in, opnd_out, dma_addr, dma_wdata, dma_rdata, m_dat_i, q;
   logic [15:0] cmd_word, rsp_word, r;
   logic opnd_load, opnd_wr, exc_ack, resume, dma_req, dma_we, dma_done, dma_fail, m_ack, m_err, m_rty;
   logic bus_timeout;
   cps_wbm_s m_req;
   logic [5:0] seen; // sticky pulses
   int fails, checks_done;
   typedef struct packed {logic br; logic [15:0] w; logic [15:0] rsp; logic [1:0] st;} cps_row_s;
   cps_row_s rows [0:9] = '{'{0, 16'h0100, 16'h0100, 0}, '{0, 16'h0200, 16'h0200, 0},
      '{0, 16'h8C00, 16'h8C00, 1}, '{0, 16'h380D, 16'h380D, 2}, '{1, 16'h2800, 16'h380D, 2},
      '{1, 16'h2A00, 16'h380D, 2}, '{1, 16'h2C00, 16'h380D, 2}, '{1, 16'h0200, 16'h380D, 2},
      '{1, 16'h0100, 16'h0100, 0}, '{1, 16'h0C00, 16'h0C00, 1}};
   cps_sequencer #(.DMA_CAPABLE(1'b1)) u_cps_sequencer (.mclk(mclk), .rst(rst), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
      .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack(wb_ack),
      .cmd_start(cmd_start), .cmd_branch(cmd_branch), .cmd_word(cmd_word), .rsp_valid(rsp_valid),
      .rsp_word(rsp_word), .rsp_ready(rsp_ready), .opnd_load(opnd_load), .opnd_in(opnd_in), .opnd_out(opnd_out),
      .opnd_wr(opnd_wr), .exc_ack(exc_ack), .resume(resume), .dma_req(dma_req), .dma_we(dma_we),
      .dma_addr(dma_addr), .dma_wdata(dma_wdata), .dma_done(dma_done), .dma_fail(dma_fail),
      .dma_rdata(dma_rdata), .m_req(m_req), .m_dat_i(m_dat_i), .m_ack(m_ack), .m_err(m_err), .m_rty(m_rty));
   cps_host_model u_cps_host_model (.mclk(mclk), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we),
      .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_o(wb_dat_i), .wb_dat_i(wb_dat_o), .wb_ack(wb_ack),
      .bus_timeout(bus_timeout));
   // clock, 40 ns period
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   // catch one-cycle pulses
   always @(posedge mclk) begin
      seen <= seen | {dma_fail, dma_done, resume, exc_ack, opnd_wr, cmd_start};
   end
   always @(posedge bus_timeout) begin
      fails++;
      report_and_stop();
   end
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : report_and_stop
   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask : check
   task automatic do_reset;
      @(posedge mclk);
      rst <= 1'b1;
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
   endtask : do_reset
   task automatic clr;
      @(negedge mclk);
      seen = '0;
   endtask : clr
   // engine offers one primitive until taken
   task automatic offer(input logic [15:0] w);
      int n;
      rsp_valid <= 1'b1;
      rsp_word <= w;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (rsp_ready !== 1'b1 && n < 40);
      rsp_valid <= 1'b0;
      rsp_word <= ~w;
      if (rsp_ready !== 1'b1) begin
         fails++;
         report_and_stop();
      end
   endtask : offer
   // memory side answers one master cycle, t = {rty, err, ack}
   task automatic term(input logic [2:0] t, input logic last, input logic [31:0] d);
      int n;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (!(m_req.cyc === 1'b1 && m_req.stb === 1'b1) && n < 40);
      if (!(m_req.cyc === 1'b1 && m_req.stb === 1'b1)) begin // no master cycle came
         fails++;
         report_and_stop();
      end
      check({27'h0, m_req.cyc, m_req.sel}, {27'h1, 4'hF}, "master request");
      check(m_req.adr, dma_addr, "master address");
      check({31'h0, m_req.we}, {31'h0, dma_we}, "master direction");
      check(m_req.dat, dma_wdata, "master write data");
      {m_rty, m_err, m_ack} <= t;
      m_dat_i <= d;
      @(posedge mclk);
      {m_rty, m_err, m_ack} <= 3'b000;
      m_dat_i <= ~d;
      if (last) dma_req <= 1'b0;
      repeat (2) @(posedge mclk);
   endtask : term
   initial begin
      {rsp_valid, rsp_word, opnd_load, opnd_in, dma_req, dma_we, dma_addr, dma_wdata} = '0;
      {m_dat_i, m_ack, m_err, m_rty, seen, fails, checks_done} = '0;
      rst = 1'b1;
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      // reset values, unmapped and read-only places
      check({wb_ack, m_req.cyc, m_req.stb}, 3'b000, "reset outputs");
      u_cps_host_model.wr(8'h40, 32'hFFFF_FFFF);
      u_cps_host_model.wr(CPS_OFS_STATUS, 32'h0000_000F);
      u_cps_host_model.rd(8'h40, q);
      check(q, 32'h0, "unmapped read");
      u_cps_host_model.get_rsp(1'b1, 1'b1, 1'b1, r);
      check({r, u_cps_host_model.last_act}, {CPS_RSP_RESET, 2'd2}, "reset response");
      u_cps_host_model.rd(CPS_OFS_STATUS, q);
      check(q, 32'h0, "reset status");
      $display("test reset done");
      // ordinary dialogues, one per row
      for (int i = 0; i < 10; i++) begin
         do_reset();
         clr();
         u_cps_host_model.command(rows[i].br, 16'hA000 + 16'(i));
         offer(rows[i].w);
         check({seen[0], cmd_branch, cmd_word}, {1'b1, rows[i].br, 16'hA000 + 16'(i)}, "command");
         u_cps_host_model.rd(CPS_OFS_STATUS, q);
         check(q[1:0], 2'b11, "posted");
         u_cps_host_model.get_rsp(1'b0, 1'b0, 1'b0, r);
         check(r, rows[i].rsp, "response");
         check(u_cps_host_model.last_act, {1'b0, rows[i].rsp[CPS_RSP_CA]}, "termination");
         u_cps_host_model.rd(CPS_OFS_STATUS, q);
         check(q[2:0], {rows[i].br, rows[i].st}, "state after read");
         if (rows[i].st == 2'd1) begin
            u_cps_host_model.get_rsp(1'b0, 1'b0, 1'b0, r);
            check(r, CPS_RSP_BUSY, "poll again");
         end
      end
      $display("test rows done");
      // exception acknowledged, then resumed
      clr();
      u_cps_host_model.command(1'b0, 16'h1234);
      offer(16'h380D);
      u_cps_host_model.get_rsp(1'b1, 1'b0, 1'b0, r);
      check({r, u_cps_host_model.last_act}, {16'h380D, 2'd1}, "exception read");
      u_cps_host_model.wr(CPS_OFS_CONTROL, 32'h1);
      u_cps_host_model.rd(CPS_OFS_STATUS, q);
      check({q[1:0], rsp_ready, seen[2]}, 4'b1001, "frozen after ack");
      u_cps_host_model.wr(CPS_OFS_CONTROL, 32'h2);
      u_cps_host_model.get_rsp(1'b0, 1'b1, 1'b1, r);
      check({seen[3], r, u_cps_host_model.last_act}, {1'b1, CPS_RSP_BUSY, 2'd3}, "resumed");
      $display("test exception done");
      // operands through the main processor
      do_reset();
      clr();
      u_cps_host_model.mem_to_cop(1);
      u_cps_host_model.xfer(1'b1, CPS_OFS_OPERAND, 4'b0011, 32'hFFFF_FFFF, q);
      check({seen[1], opnd_out}, {1'b1, 32'h2222_FFFF}, "operand in");
      opnd_load <= 1'b1;
      opnd_in <= 32'h5A5A_C3C3;
      @(posedge mclk);
      opnd_load <= 1'b0;
      u_cps_host_model.cop_to_mem(2);
      check(u_cps_host_model.mem[2], 32'h5A5A_C3C3, "operand out");
      $display("test operand done");
      // bus master: retry, ack read, error write
      clr();
      {dma_req, dma_we, dma_addr, m_dat_i} <= {2'b10, 32'hFEDC_BA98, 32'hF452_0FF2};
      term(3'b100, 1'b0, 32'h0BAD_F00D);
      term(3'b001, 1'b1, 32'h0BAD_F00D);
      check({seen[4], dma_rdata}, {1'b1, 32'h0BAD_F00D}, "master read");
      {dma_req, dma_we, dma_addr, dma_wdata} <= {2'b11, 32'h0000_0FFC, 32'hC0DE_0001};
      term(3'b010, 1'b1, 32'h0BAD_F00D);
      u_cps_host_model.rd(CPS_OFS_STATUS, q);
      check({seen[5], q[3]}, 2'b11, "master error");
      u_cps_host_model.wr(CPS_OFS_CONTROL, 32'h4);
      u_cps_host_model.rd(CPS_OFS_STATUS, q);
      check(q[3], 1'b0, "error cleared");
      $display("test master done");
      report_and_stop();
   end
endmodule : coprocessor_protocol_sequencer_test
